// file: common/flash_cfg_defines.svh
`ifndef FLASH_CFG_DEFINES_SVH
`define FLASH_CFG_DEFINES_SVH

// =============================================================
// Opcodes
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLR 8'h04
`define OP_VOL_ENABLE 8'h50
`define OP_RD_SR1 8'h05
`define OP_RD_SR2 8'h35
`define OP_RD_SR3 8'h15
`define OP_WR_SR1 8'h01
`define OP_WR_SR2 8'h31
`define OP_WR_SR3 8'h11
`define OP_RD_UPPER 8'hC8
`define OP_WR_UPPER 8'hC5

// =============================================================
// Bit counts at chip select rise
`define BITS_OPCODE 5'h08
`define BITS_ONE_BYTE 5'h10
`define BITS_TWO_BYTE 5'h18

// =============================================================
// Field positions
`define SR1_BUSY 0
`define SR1_LATCH 1
`define SR1_STATUS_PROTECT_LOW 7
`define SR2_STATUS_PROTECT_HIGH 0
`define SR2_QE 1
`define SR2_SUS_B 2
`define SR2_LB_LO 3
`define SR2_LB_HI 5
`define SR2_CMP 6
`define SR2_SUS_A 7
`define SR3_ADS 0
`define SR3_ADP 1
`define SR3_DRV_LO 5
`define SR3_DRV_HI 6
`define SR3_HOLD 7

// =============================================================
// Writable masks and reset values
`define SR1_WR_MASK 8'hFC
`define SR2_WR_MASK 8'h43
`define SR3_WR_MASK 8'hE3
`define SR1_RESET 8'h00
`define SR2_RESET 8'h00
`define SR3_RESET 8'h00
`define UPPER_RESET 8'h00

// =============================================================
// Timing
`define CLK_PERIOD_NS 20
`define STATUS_WRITE_NS 5000000

`endif

// file: common/flash_cfg_pkg.sv
package flash_cfg_pkg;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
    } link_in_t;

    typedef enum logic [3:0] {
        ST_OPCODE = 4'b0001,
        ST_DATA_IN = 4'b0010,
        ST_DATA_OUT = 4'b0100,
        ST_SKIP = 4'b1000
    } link_state_t;

    typedef struct packed {
        logic [4:0] block_protect_field;
        logic protect_complement;
        logic quad_enable;
        logic current_addr_width;
        logic power_up_addr_width;
        logic [1:0] drive_strength;
        logic hold_reset_select;
    } cfg_out_t;

endpackage

// file: logic/flash_cfg_status.sv
`timescale 1ns/1ps
`include "flash_cfg_defines.svh"

// Function
// - Latch-set opcode sets the write latch.
// - Writes need the write latch (or, for status writes, volatile enable) set beforehand, else rejected.
// - Latch-set ignored while volatile status-write enable is active.
// - Volatile enable keeps the latch; next status write updates volatile copies only.
// - Volatile enable ignored while the write latch is set.
// - Software reset reloads volatile status bits from stored values; power-up reset loads the reset constants into both copies.
// - Latch-clear opcode clears the write latch.
// - Latch clears at power-up, reset, on completion of status writes and on write_done; upper address writes leave it set.
// - Status reads accepted anytime; each shifts out its register bits 7 to 0.
// - 01h takes one or two bytes; 31h and 11h take exactly one.
// - Status write changes only the listed writable bits, plus the stored security lock bits, which are ORed in.
// - Security lock bits are one-time programmable.
// - Status write needs prior latch-set or volatile enable.
// - Status write leaves suspend flags, latch and busy untouched.
// - Chip select must rise after 8 or 16 data bits, else discard.
// - Chip select rise starts timed write; busy high, then latch clears.
// - Hardware protected mode refuses all status writes.
// - Upper address read samples on rise, shifts out MSB first on fall.
// - Three-byte mode uses upper byte as address bits 31 to 24.
// - Upper address write accepted only with write latch set.
// - Upper address register clears at power-up and software reset.
// - Four-byte mode commands overwrite the upper byte register.
// - Status read repeats while chip select stays low.
// - All link bytes travel most significant bit first.
module flash_cfg_status #(
    parameter int unsigned TW_CYCLES =
        (`STATUS_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Link pins
    input wire flash_cfg_pkg::link_in_t link_in,
    output logic so_out,
    output logic so_oe,
    // Neighbouring command logic
    input wire logic soft_reset,
    input wire logic array_busy,
    input wire logic write_done,
    input wire logic suspend_a,
    input wire logic suspend_b,
    input wire logic addr_hi_valid,
    input wire logic [7:0] addr_hi_in,
    // Configuration to the array side
    output flash_cfg_pkg::cfg_out_t cfg_out,
    output logic write_latch,
    output logic busy_flag,
    output logic [7:0] array_addr_hi
);

    // =============================================================
    // Pin synchronisers and edges
    flash_cfg_pkg::link_in_t meta_ff;
    flash_cfg_pkg::link_in_t pin_ff;
    flash_cfg_pkg::link_in_t prev_ff;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_ff <= 4'hD;
            pin_ff <= 4'hD;
            prev_ff <= 4'hD;
        end else begin
            meta_ff <= link_in;
            pin_ff <= meta_ff;
            prev_ff <= pin_ff;
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_low;
    assign sck_rise = pin_ff.sck & ~prev_ff.sck;
    assign sck_fall = ~pin_ff.sck & prev_ff.sck;
    assign cs_rise = pin_ff.cs_n & ~prev_ff.cs_n;
    assign cs_low = ~pin_ff.cs_n;

    // =============================================================
    // Link shifter and command state
    flash_cfg_pkg::link_state_t state_ff;
    logic [4:0] cnt_ff;
    logic [7:0] rx_ff;
    logic [7:0] op_ff;
    logic [7:0] byte1_ff;
    logic [7:0] byte2_ff;
    logic [7:0] tx_ff;
    logic [7:0] nxt_rx;
    logic [7:0] sr1_view;
    logic [7:0] sr2_view;
    logic [7:0] sr3_view;
    logic [7:0] upper_ff;
    logic is_read_op;
    logic is_data_op;
    logic [7:0] read_sel;

    assign nxt_rx = {rx_ff[6:0], pin_ff.si};

    always_comb begin
        is_read_op = 1'b0;
        read_sel = 8'h00;
        unique case (nxt_rx)
            `OP_RD_SR1: begin
                is_read_op = 1'b1;
                read_sel = sr1_view;
            end
            `OP_RD_SR2: begin
                is_read_op = 1'b1;
                read_sel = sr2_view;
            end
            `OP_RD_SR3: begin
                is_read_op = 1'b1;
                read_sel = sr3_view;
            end
            `OP_RD_UPPER: begin
                is_read_op = 1'b1;
                read_sel = upper_ff;
            end
            default: begin
                is_read_op = 1'b0;
                read_sel = 8'h00;
            end
        endcase
    end

    assign is_data_op = (nxt_rx == `OP_WR_SR1) || (nxt_rx == `OP_WR_SR2)
        || (nxt_rx == `OP_WR_SR3) || (nxt_rx == `OP_WR_UPPER);

    always_ff @(posedge ref_clk) begin
        if (!rst_n || !cs_low) begin
            state_ff <= flash_cfg_pkg::ST_OPCODE;
            cnt_ff <= 5'h00;
            rx_ff <= 8'h00;
        end else if (sck_rise) begin
            rx_ff <= nxt_rx;
            if (cnt_ff != 5'h1F) begin
                cnt_ff <= cnt_ff + 5'h01;
            end
            if (state_ff == flash_cfg_pkg::ST_OPCODE && cnt_ff == 5'h07) begin
                if (is_read_op) begin
                    state_ff <= flash_cfg_pkg::ST_DATA_OUT;
                end else if (is_data_op) begin
                    state_ff <= flash_cfg_pkg::ST_DATA_IN;
                end else begin
                    state_ff <= flash_cfg_pkg::ST_SKIP;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            op_ff <= 8'h00;
            byte1_ff <= 8'h00;
            byte2_ff <= 8'h00;
        end else if (cs_low && sck_rise) begin
            if (cnt_ff == 5'h07) begin
                op_ff <= nxt_rx;
            end
            if (cnt_ff == 5'h0F) begin
                byte1_ff <= nxt_rx;
            end
            if (cnt_ff == 5'h17) begin
                byte2_ff <= nxt_rx;
            end
        end
    end

    // =============================================================
    // Read shifter
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_ff <= 8'h00;
            so_out <= 1'b0;
        end else if (cs_low && sck_rise && state_ff == flash_cfg_pkg::ST_OPCODE
                     && cnt_ff == 5'h07) begin
            tx_ff <= read_sel;
        end else if (cs_low && sck_fall && state_ff == flash_cfg_pkg::ST_DATA_OUT) begin
            // shift out on falling edge, MSB first
            so_out <= tx_ff[7];
            // byte rotates so the register repeats
            tx_ff <= {tx_ff[6:0], tx_ff[7]};
        end
    end

    assign so_oe = cs_low && (state_ff == flash_cfg_pkg::ST_DATA_OUT);

    // =============================================================
    // Frame-end decode
    logic busy_ff;
    logic wel_ff;
    logic vwe_ff;
    logic hw_protect;
    logic busy_any;
    logic op_len_ok;
    logic is_sr_write;
    logic sr_write_ok;
    logic latch_set_ok;
    logic vol_en_ok;
    logic latch_clr_ok;
    logic upper_wr_ok;
    logic wr_done_pulse;
    logic [7:0] vol1_ff;
    logic [7:0] vol2_ff;
    logic [7:0] vol3_ff;
    logic [7:0] nv1_ff;
    logic [7:0] nv2_ff;
    logic [7:0] nv3_ff;

    assign busy_any = busy_ff | array_busy;
    // protected while status_protect_low set, SR2_STATUS_PROTECT_HIGH clear and protect pin low
    assign hw_protect = vol1_ff[`SR1_STATUS_PROTECT_LOW] & ~vol2_ff[`SR2_STATUS_PROTECT_HIGH] & ~pin_ff.wp_n;
    assign is_sr_write = (op_ff == `OP_WR_SR1) || (op_ff == `OP_WR_SR2)
        || (op_ff == `OP_WR_SR3);

    always_comb begin
        op_len_ok = 1'b0;
        if (op_ff == `OP_WR_SR1) begin
            op_len_ok = (cnt_ff == `BITS_ONE_BYTE) || (cnt_ff == `BITS_TWO_BYTE);
        end else if (is_sr_write || op_ff == `OP_WR_UPPER) begin
            op_len_ok = (cnt_ff == `BITS_ONE_BYTE);
        end
    end

    // single-byte commands need exactly eight bits
    assign latch_set_ok = cs_rise && op_ff == `OP_LATCH_SET && cnt_ff == `BITS_OPCODE
        && !busy_any && !vwe_ff;
    assign latch_clr_ok = cs_rise && op_ff == `OP_LATCH_CLR && cnt_ff == `BITS_OPCODE
        && !busy_any;
    assign vol_en_ok = cs_rise && op_ff == `OP_VOL_ENABLE && cnt_ff == `BITS_OPCODE
        && !busy_any && !wel_ff;
    assign sr_write_ok = cs_rise && is_sr_write && op_len_ok && !busy_any
        && (wel_ff || vwe_ff) && !hw_protect;
    // upper byte write needs the latch
    assign upper_wr_ok = cs_rise && op_ff == `OP_WR_UPPER && op_len_ok
        && !busy_any && wel_ff;

    // =============================================================
    // Status write cycle timer
    logic [$clog2(TW_CYCLES + 1)-1:0] tw_cnt_ff;

    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
            busy_ff <= 1'b0;
            tw_cnt_ff <= '0;
        end else if (sr_write_ok && !vwe_ff) begin
            // self-timed cycle starts at chip select rise
            busy_ff <= 1'b1;
            tw_cnt_ff <= ($clog2(TW_CYCLES + 1))'(TW_CYCLES);
        end else if (busy_ff) begin
            tw_cnt_ff <= tw_cnt_ff - 1'b1;
            if (tw_cnt_ff == 1) begin
                busy_ff <= 1'b0;
            end
        end
    end

    assign wr_done_pulse = busy_ff && (tw_cnt_ff == 1);

    // =============================================================
    // Write latch and volatile enable
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
            wel_ff <= 1'b0;
        end else if (wr_done_pulse || write_done || latch_clr_ok) begin
            // clear on latch-clear and completed writes
            wel_ff <= 1'b0;
        end else if (latch_set_ok) begin
            wel_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
            vwe_ff <= 1'b0;
        end else if (latch_clr_ok || sr_write_ok) begin
            vwe_ff <= 1'b0;
        end else if (vol_en_ok) begin
            vwe_ff <= 1'b1;
        end
    end

    // =============================================================
    // Status registers
    logic wr_sr1;
    logic wr_sr2;
    logic wr_sr3;
    logic [7:0] sr2_data;
    assign wr_sr1 = sr_write_ok && op_ff == `OP_WR_SR1;
    assign wr_sr2 = sr_write_ok && ((op_ff == `OP_WR_SR1 && cnt_ff == `BITS_TWO_BYTE)
        || op_ff == `OP_WR_SR2);
    assign wr_sr3 = sr_write_ok && op_ff == `OP_WR_SR3;
    assign sr2_data = (op_ff == `OP_WR_SR2) ? byte1_ff : byte2_ff;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            nv1_ff <= `SR1_RESET;
            nv2_ff <= `SR2_RESET;
            nv3_ff <= `SR3_RESET;
        end else if (!vwe_ff) begin
            if (wr_sr1) begin
                nv1_ff <= (nv1_ff & ~`SR1_WR_MASK) | (byte1_ff & `SR1_WR_MASK);
            end
            if (wr_sr2) begin
                nv2_ff <= (nv2_ff & ~`SR2_WR_MASK) | (sr2_data & `SR2_WR_MASK);
                nv2_ff[`SR2_LB_HI:`SR2_LB_LO] <= nv2_ff[`SR2_LB_HI:`SR2_LB_LO]
                    | sr2_data[`SR2_LB_HI:`SR2_LB_LO];
            end
            if (wr_sr3) begin
                nv3_ff <= (nv3_ff & ~`SR3_WR_MASK) | (byte1_ff & `SR3_WR_MASK);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            vol1_ff <= `SR1_RESET;
            vol2_ff <= `SR2_RESET;
            vol3_ff <= `SR3_RESET;
        end else if (soft_reset) begin
            // reload volatile copies from stored values
            vol1_ff <= nv1_ff;
            vol2_ff <= nv2_ff;
            vol3_ff <= nv3_ff;
        end else begin
            if (wr_sr1) begin
                vol1_ff <= (vol1_ff & ~`SR1_WR_MASK) | (byte1_ff & `SR1_WR_MASK);
            end
            if (wr_sr2) begin
                vol2_ff <= (vol2_ff & ~`SR2_WR_MASK) | (sr2_data & `SR2_WR_MASK);
            end
            if (wr_sr3) begin
                vol3_ff <= (vol3_ff & ~`SR3_WR_MASK) | (byte1_ff & `SR3_WR_MASK);
            end
        end
    end

    // suspend, latch and busy come from their own sources
    assign sr1_view = {vol1_ff[7:2], wel_ff, busy_any};
    assign sr2_view = {suspend_a, vol2_ff[`SR2_CMP], nv2_ff[`SR2_LB_HI:`SR2_LB_LO],
        suspend_b, vol2_ff[`SR2_QE], vol2_ff[`SR2_STATUS_PROTECT_HIGH]};
    assign sr3_view = vol3_ff & `SR3_WR_MASK;

    // =============================================================
    // Upper address byte
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
            // cleared on power-up and software reset
            upper_ff <= `UPPER_RESET;
        end else if (upper_wr_ok) begin
            upper_ff <= byte1_ff;
        end else if (addr_hi_valid && vol3_ff[`SR3_ADS]) begin
            upper_ff <= addr_hi_in;
        end
    end

    // three-byte mode supplies bits 31 to 24
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            array_addr_hi <= 8'h00;
        end else begin
            array_addr_hi <= vol3_ff[`SR3_ADS] ? addr_hi_in : upper_ff;
        end
    end

    // =============================================================
    // Outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_out <= '0;
            write_latch <= 1'b0;
            busy_flag <= 1'b0;
        end else begin
            cfg_out.block_protect_field <= vol1_ff[6:2];
            cfg_out.protect_complement <= vol2_ff[`SR2_CMP];
            cfg_out.quad_enable <= vol2_ff[`SR2_QE];
            cfg_out.current_addr_width <= vol3_ff[`SR3_ADS];
            cfg_out.power_up_addr_width <= vol3_ff[`SR3_ADP];
            cfg_out.drive_strength <= vol3_ff[`SR3_DRV_HI:`SR3_DRV_LO];
            cfg_out.hold_reset_select <= vol3_ff[`SR3_HOLD];
            write_latch <= wel_ff;
            busy_flag <= busy_any;
        end
    end

    // =============================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_frame_end(logic [7:0] op, logic [4:0] n);
        cs_rise && op_ff == op && cnt_ff == n;
    endsequence

    a_latch_set_sets: assert property (
        s_frame_end(`OP_LATCH_SET, `BITS_OPCODE) and (!busy_any && !vwe_ff
        && !soft_reset && !write_done) |=> wel_ff ##1 write_latch)
        else $error("latch set opcode did not set the latch");

    a_latch_set_blocked: assert property (
        s_frame_end(`OP_LATCH_SET, `BITS_OPCODE) and (vwe_ff && !wel_ff) |=> !wel_ff)
        else $error("latch set taken while volatile enable active");

    a_vol_en_keeps: assert property (
        s_frame_end(`OP_VOL_ENABLE, `BITS_OPCODE) and (!write_done && !soft_reset)
        |=> wel_ff == $past(wel_ff))
        else $error("volatile enable changed the latch");

    a_vol_en_blocked: assert property (
        s_frame_end(`OP_VOL_ENABLE, `BITS_OPCODE) and (wel_ff && !vwe_ff) |=> !vwe_ff)
        else $error("volatile enable taken while latch set");

    a_latch_clear: assert property (
        s_frame_end(`OP_LATCH_CLR, `BITS_OPCODE) and !busy_any |=> !wel_ff [*2])
        else $error("latch clear opcode did not clear the latch");

    a_busy_window: assert property (
        sr_write_ok && !vwe_ff && !soft_reset |=> busy_ff [*2] ##0 busy_flag)
        else $error("status write cycle did not raise busy");

    a_done_clears: assert property (
        $fell(busy_ff) && !soft_reset |-> !wel_ff)
        else $error("latch still set after write cycle");

    a_bad_length: assert property (
        cs_rise && is_sr_write && !op_len_ok && !soft_reset |=> $stable(vol1_ff)
        && $stable(vol2_ff) && $stable(vol3_ff))
        else $error("status write with bad length changed a register");

    a_lock_otp: assert property (
        (|($past(nv2_ff[`SR2_LB_HI:`SR2_LB_LO]) & ~nv2_ff[`SR2_LB_HI:`SR2_LB_LO])) == 1'b0)
        else $error("security lock bit returned to zero");

    a_hw_protect: assert property (
        cs_rise && is_sr_write && hw_protect |-> !sr_write_ok ##1 $stable(vol1_ff))
        else $error("status write executed while protected");

    a_upper_needs_latch: assert property (
        s_frame_end(`OP_WR_UPPER, `BITS_ONE_BYTE) and (!wel_ff && !addr_hi_valid
        && !soft_reset) |=> $stable(upper_ff))
        else $error("upper byte written without latch");

    a_upper_mode: assert property (
        !vol3_ff[`SR3_ADS] && $stable(vol3_ff) |=> array_addr_hi == $past(upper_ff))
        else $error("three-byte mode did not use upper byte");

endmodule

// file: sim/flash_status_config_cmds_tb_top.sv
`timescale 1ns/1ps
`include "flash_cfg_defines.svh"

module flash_status_config_cmds_tb_top;
    localparam int TW = 400;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic soft_reset = 1'b0;
    logic array_busy = 1'b0;
    logic write_done = 1'b0;
    logic suspend_a = 1'b0;
    logic suspend_b = 1'b0;
    logic addr_hi_valid = 1'b0;
    logic [7:0] addr_hi_in = 8'h00;
    logic wp = 1'b1;
    flash_cfg_pkg::link_in_t link_in;
    flash_cfg_pkg::cfg_out_t cfg_out;
    logic so_out, so_oe, write_latch, busy_flag;
    logic [7:0] array_addr_hi;
    logic [15:0] rx;
    logic [7:0] ops [4] = '{`OP_WR_SR1, `OP_WR_SR1, `OP_WR_SR2, `OP_WR_SR3};
    int nbs [4] = '{16, 8, 8, 8};
    int num_errors = 0, n_tests = 0, busy_len = 0, i = 0;
    int v1 = 0, v2 = 0, v3 = 0, n1 = 0, n2 = 0, n3 = 0, lb = 0, up = 0, latch = 0, vol = 0;

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (busy_flag === 1'b1) busy_len <= busy_len + 1;

    flash_cfg_status #(.TW_CYCLES(TW)) i_flash_cfg_status (
        .ref_clk(ref_clk), .rst_n(rst_n), .link_in(link_in), .so_out(so_out),
        .so_oe(so_oe), .soft_reset(soft_reset), .array_busy(array_busy),
        .write_done(write_done), .suspend_a(suspend_a), .suspend_b(suspend_b),
        .addr_hi_valid(addr_hi_valid), .addr_hi_in(addr_hi_in), .cfg_out(cfg_out),
        .write_latch(write_latch), .busy_flag(busy_flag), .array_addr_hi(array_addr_hi)
    );
    spi_host_model i_spi_host_model (
        .ref_clk(ref_clk), .link_in(link_in), .so_out(so_out), .so_oe(so_oe)
    );

    // ==========================================
    // Reference model and checks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] exp_one(input int b);
        return 8'(v1 | (latch << 1) | b);
    endfunction

    function automatic logic [7:0] exp_two();
        return 8'((suspend_a << 7) | v2 | (lb << 3) | (suspend_b << 2));
    endfunction

    task automatic rd(input logic [7:0] op, input logic [7:0] exp);
        i_spi_host_model.frame({op, 24'h00_0000}, 16, rx);
        check({8'h00, rx[7:0]}, {8'h00, exp});
    endtask

    task automatic rd_all;
        rd(`OP_RD_SR1, exp_one(0));
        rd(`OP_RD_SR2, exp_two());
        rd(`OP_RD_SR3, 8'(v3));
        rd(`OP_RD_UPPER, 8'(up));
    endtask

    task automatic cmd(input logic [7:0] op);
        i_spi_host_model.frame({op, 24'h00_0000}, 8, rx);
        if (op == `OP_LATCH_SET && vol == 0) latch = 1;
        if (op == `OP_LATCH_CLR) latch = 0;
        if (op == `OP_LATCH_CLR) vol = 0;
        if (op == `OP_VOL_ENABLE && latch == 0) vol = 1;
    endtask

    task automatic wup(input logic [7:0] u);
        i_spi_host_model.frame({`OP_WR_UPPER, u, 16'h0000}, 16, rx);
        if (latch != 0) up = u;
    endtask

    task automatic wsr(input logic [7:0] op, input logic [15:0] d, input int nb);
        logic [7:0] s2;
        int ok;
        int two;
        two = (op == `OP_WR_SR1 && nb == 16) || (op == `OP_WR_SR2 && nb == 8);
        s2 = (op == `OP_WR_SR1) ? d[7:0] : d[15:8];
        ok = (latch || vol) && !(v1[7] && !v2[0] && !wp);
        ok = ok && (nb == 8 || (nb == 16 && op == `OP_WR_SR1));
        busy_len = 0;
        i_spi_host_model.frame({op, d, 8'h00}, 8 + nb, rx);
        if (ok) begin
            if (op == `OP_WR_SR1) v1 = d[15:8] & 8'hFC;
            if (two) v2 = s2 & 8'h43;
            if (op == `OP_WR_SR3) v3 = d[15:8] & 8'hE3;
            if (vol == 0) begin
                if (op == `OP_WR_SR1) n1 = v1;
                if (two) n2 = v2;
                if (op == `OP_WR_SR3) n3 = v3;
                if (two) lb = lb | s2[5:3];
                rd(`OP_RD_SR1, exp_one(1));
                repeat (TW) @(negedge ref_clk);
                check(16'(busy_len), 16'(TW));
                latch = 0;
            end
            vol = 0;
        end
    endtask

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================
    // Watchdog, well beyond the expected run
    initial begin
        repeat (40000) @(posedge ref_clk);
        num_errors++;
        final_report();
    end

    // ==========================================
    // Test sequence
    initial begin
        void'($urandom(33));
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        rd_all();
        wsr(`OP_WR_SR1, 16'hFC00, 8);
        rd_all();
        cmd(`OP_LATCH_SET);
        check(16'(write_latch), 16'h0001);
        cmd(`OP_VOL_ENABLE);
        cmd(`OP_LATCH_CLR);
        wsr(`OP_WR_SR1, 16'hFC00, 8);
        rd(`OP_RD_SR1, exp_one(0));
        cmd(`OP_VOL_ENABLE);
        cmd(`OP_LATCH_SET);
        rd(`OP_RD_SR1, exp_one(0));
        wsr(`OP_WR_SR1, 16'($urandom), 16);
        rd_all();
        check(16'(busy_len), 16'h0000);
        for (i = 0; i < 8; i++) begin
            suspend_a = 1'($urandom);
            suspend_b = 1'($urandom);
            cmd(`OP_LATCH_SET);
            wsr(ops[i % 4], 16'($urandom), nbs[i % 4]);
            rd_all();
        end
        cmd(`OP_LATCH_SET);
        wsr(`OP_WR_SR1, 16'h0000, 12);
        wsr(`OP_WR_SR2, 16'h0000, 16);
        i_spi_host_model.frame({`OP_LATCH_CLR, 24'h00_0000}, 7, rx);
        rd_all();
        wsr(`OP_WR_SR1, 16'h8000, 16);
        cmd(`OP_LATCH_SET);
        wsr(`OP_WR_SR3, 16'h0000, 8);
        i_spi_host_model.set_wp(1'b0);
        wp = 1'b0;
        cmd(`OP_LATCH_SET);
        wsr(`OP_WR_SR1, 16'h0000, 8);
        rd(`OP_RD_SR1, exp_one(0));
        cmd(`OP_LATCH_CLR);
        i_spi_host_model.set_wp(1'b1);
        wp = 1'b1;
        wup(8'hA5);
        rd(`OP_RD_UPPER, 8'(up));
        cmd(`OP_LATCH_SET);
        wup(8'($urandom));
        rd(`OP_RD_UPPER, 8'(up));
        check(16'(array_addr_hi), 16'(up));
        wsr(`OP_WR_SR3, 16'h0100, 8);
        addr_hi_in = 8'($urandom);
        addr_hi_valid = 1'b1;
        @(negedge ref_clk);
        addr_hi_valid = 1'b0;
        up = addr_hi_in;
        repeat (4) @(negedge ref_clk);
        check(16'(array_addr_hi), 16'(addr_hi_in));
        rd(`OP_RD_UPPER, 8'(up));
        cmd(`OP_LATCH_SET);
        write_done = 1'b1;
        @(negedge ref_clk);
        write_done = 1'b0;
        latch = 0;
        repeat (3) @(negedge ref_clk);
        check(16'(write_latch), 16'h0000);
        array_busy = 1'b1;
        rd(`OP_RD_SR1, exp_one(1));
        array_busy = 1'b0;
        i_spi_host_model.frame({`OP_RD_SR2, 24'h00_0000}, 24, rx);
        check(rx, {exp_two(), exp_two()});
        cmd(`OP_VOL_ENABLE);
        wsr(`OP_WR_SR1, 16'($urandom), 16);
        cmd(`OP_LATCH_SET);
        wup(8'($urandom));
        soft_reset = 1'b1;
        @(negedge ref_clk);
        soft_reset = 1'b0;
        {v1, v2, v3, up, latch, vol} = {n1, n2, n3, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
        repeat (4) @(negedge ref_clk);
        rd_all();
        check(16'(cfg_out), 16'({v1[6:2], v2[6], v2[1], v3[0], v3[1], v3[6:5], v3[7]}));
        final_report();
    end
endmodule

// file: sim/spi_host_model.sv
`timescale 1ns/1ps

module spi_host_model (
    // Clock
    input wire logic ref_clk,
    // Link pins
    output flash_cfg_pkg::link_in_t link_in,
    input wire logic so_out,
    input wire logic so_oe
);
    initial link_in = '{cs_n: 1'b1, sck: 1'b1, si: 1'b0, wp_n: 1'b1};

    // ==========================================
    // Frame driver, mode 3, clock idles high
    // MSB first framing
    task automatic frame(input logic [31:0] tx, input int nbits, output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        link_in.cs_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        for (i = 0; i < nbits; i++) begin
            link_in.sck = 1'b0;
            link_in.si = tx[31 - i];
            repeat (4) @(negedge ref_clk);
            link_in.sck = 1'b1;
            repeat (4) @(negedge ref_clk);
            rx = {rx[14:0], so_oe ? so_out : 1'b1};
        end
        link_in.cs_n = 1'b1;
        // Released data line shows no stale bit
        link_in.si = ~link_in.si;
        repeat (8) @(negedge ref_clk);
    endtask

    task automatic set_wp(input logic lvl);
        link_in.wp_n = lvl;
    endtask
endmodule
